// >>> ssr_pkg.sv
/*
  Package for the starter status reporting block: register offsets, state
  and origin codes, reset values, timing constants and the condition structs.
  Assumes a single 200 MHz clock and a 32-bit APB register bus.
*/
package ssr_pkg;

  // Register byte offsets, one aligned word each
  localparam logic [7:0] OFS_STATE  = 8'h00; // Operating state code
  localparam logic [7:0] OFS_ORIGIN = 8'h04; // Command origin code
  localparam logic [7:0] OFS_FLAGS  = 8'h08; // Condition flag word
  localparam logic [7:0] OFS_CTRL   = 8'h0c; // Report control

  // Field positions
  localparam int CTRL_FREEZE_BIT = 0; // Freeze software view
  localparam int FLAG_REMOTE_BIT = 8; // Remote control flag
  localparam int FLAG_RAMPUP_BIT = 4; // Ramp up flag
  localparam int FLAG_FAULT_BIT  = 15; // Fault flag

  // Operating state codes
  localparam logic [3:0] ST_READY    = 4'h0; // Ready to start
  localparam logic [3:0] ST_INITTEST = 4'h1; // Initial test
  localparam logic [3:0] ST_FAULT    = 4'h2; // Fault present
  localparam logic [3:0] ST_RAMPUP   = 4'h3; // Acceleration
  localparam logic [3:0] ST_FULLV    = 4'h4; // Full voltage
  localparam logic [3:0] ST_BYPASS   = 4'h5; // Bypass closed
  localparam logic [3:0] ST_RESERVED = 4'h6; // Never reported
  localparam logic [3:0] ST_RAMPDN   = 4'h7; // Deceleration
  localparam logic [3:0] ST_BRAKING  = 4'h8; // Braking
  localparam logic [3:0] ST_DIRCHG   = 4'h9; // Direction change
  localparam logic [3:0] ST_INCHING  = 4'ha; // Inching
  localparam logic [3:0] ST_STDELAY  = 4'hb; // Start delay
  localparam logic [3:0] ST_RSDELAY  = 4'hc; // Restart delay
  localparam logic [3:0] ST_DISABLED = 4'hd; // Generally disabled
  localparam logic [3:0] ST_CONFIG   = 4'he; // Configuration

  // Command sources, origin code is source times two plus remote
  localparam logic [2:0] SRC_LAST = 3'h5; // Slot two, highest legal source

  // Reset values
  localparam logic [3:0]  RST_STATE  = ST_CONFIG; // Config after reset
  localparam logic [3:0]  RST_ORIGIN = 4'h0;      // Panel keys local
  localparam logic [15:0] RST_FLAGS  = 16'h0000;  // All flags clear

  // Settling time after reset before live state and flag conditions are reported
  localparam int CLK_PERIOD_NS = 5;   // 200 MHz
  localparam int INIT_TIME_NS  = 100; // Least settling time
  localparam logic [4:0] INIT_CYCLES =
    5'((INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Flag word conditions, bit 15 down to bit 0
  typedef struct packed {
    logic fault;            // Fault condition
    logic alarm;            // Alarm condition
    logic post_stop;        // Post-stop interval running
    logic pre_start;        // Pre-start interval running
    logic reverse;          // Reverse rotation
    logic direction_change; // Reversal in progress
    logic braking;          // Braking
    logic remote_control;   // Remote, else local
    logic ramp_down;        // Decelerating
    logic bypass_closed;    // Bypass contactor closed
    logic full_voltage;     // Full voltage applied
    logic ramp_up;          // Accelerating
    logic initial_test;     // Pre-start tests
    logic inching;          // Inching active
    logic all_enables;      // Every enabling means active
    logic motor_enabled;    // Motor enabled
  } ssr_flags_t;

  // Configuration mode causes
  typedef struct packed {
    logic initializing;  // System initialization
    logic fw_download;   // Firmware download
    logic commissioning; // Guided commissioning
    logic panel_copy;    // Settings copy with panel
    logic incompatible;  // Incompatible settings
  } ssr_cfg_t;

  // All condition inputs from the starter controller
  typedef struct packed {
    ssr_flags_t flags;         // Flag word sources
    ssr_cfg_t   cfg;           // Configuration causes
    logic       start_delay;   // Start delay running
    logic       restart_delay; // Restart delay running
    logic [2:0] cmd_src;       // Active command source 0..5
  } ssr_cond_t;

  // Report phase after reset
  typedef enum logic {
    PH_INIT = 1'b0, // Holding config report
    PH_RUN  = 1'b1  // Reporting live conditions
  } ssr_phase_t;

endpackage

// >>> ssr_state_encoder.sv
/*
  Operating state code encoder: ranks the live conditions and registers the
  resulting code. Assumes inputs come from logic on the same clock.
*/
`timescale 1ns/1ps
module ssr_state_encoder (
  input  wire logic              clk,           // System clock
  input  wire logic              rstn,          // Sync reset, active low
  input  wire ssr_pkg::ssr_flags_t flags,       // Condition flags
  input  wire ssr_pkg::ssr_cfg_t cfg,           // Configuration causes
  input  wire logic              start_delay,   // Start delay running
  input  wire logic              restart_delay, // Restart delay running
  input  wire logic              hold,          // Settling after reset
  output logic [3:0]             state_code     // Registered state code
);

  logic [3:0] next_state_code; // Ranked code

  // Rank conditions, most severe first; code 6 is never produced
  always_comb begin
    if (hold || (|cfg)) begin
      next_state_code = ssr_pkg::ST_CONFIG;
    end else if (flags.fault) begin
      next_state_code = ssr_pkg::ST_FAULT;
    end else if (flags.initial_test) begin
      next_state_code = ssr_pkg::ST_INITTEST;
    end else if (!flags.all_enables) begin
      next_state_code = ssr_pkg::ST_DISABLED;
    end else if (flags.braking) begin
      next_state_code = ssr_pkg::ST_BRAKING;
    end else if (flags.direction_change) begin
      next_state_code = ssr_pkg::ST_DIRCHG;
    end else if (flags.inching) begin
      next_state_code = ssr_pkg::ST_INCHING;
    end else if (flags.ramp_down) begin
      next_state_code = ssr_pkg::ST_RAMPDN;
    end else if (flags.ramp_up) begin
      next_state_code = ssr_pkg::ST_RAMPUP;
    end else if (flags.bypass_closed) begin
      next_state_code = ssr_pkg::ST_BYPASS;
    end else if (flags.full_voltage) begin
      next_state_code = ssr_pkg::ST_FULLV;
    end else if (start_delay) begin
      next_state_code = ssr_pkg::ST_STDELAY;
    end else if (restart_delay) begin
      next_state_code = ssr_pkg::ST_RSDELAY;
    end else begin
      next_state_code = ssr_pkg::ST_READY;
    end
  end

  // Register the code
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_code <= ssr_pkg::RST_STATE;
    end else begin
      state_code <= next_state_code;
    end
  end

  // Braking alone outranks the motion states
  a_brake_code : assert property (@(posedge clk) disable iff (!rstn)
    (!hold && !(|cfg) && flags.braking && !flags.fault &&
     !flags.initial_test && flags.all_enables)
    |=> state_code == ssr_pkg::ST_BRAKING)
    else $error("braking did not give state 8");

endmodule

// >>> ssr_status.sv
/*
  Starter status reporting top: APB slave with three read-only status
  registers and a report control register, the settling sequence after
  reset, command origin coding and the condition flag word.
  Assumes condition inputs come from the starter controller on the same
  clock, and an APB master that follows the usual setup/access phases.
*/
// Functional notes
// - State code readable, legal range zero to fourteen
// - Codes: 0 ready, 1 test, 2 fault
// - Codes 3 ramp, 4 full, 5 bypass; 6 unused
// - Codes 7 through 13 for remaining operations
// - Code 14 for any configuration cause
// - Origin code: source pairs zero to eleven
// - Even origin code local, odd remote
// - Bit0 motor enabled, bit1 all enables
// - Bit2 inching, bit3 initial tests
// - Bits 4-6 ramp up, full voltage, bypass
// - Bit7 ramp down, bit8 remote control
// - Bits 9-11 braking, reversal, reverse rotation
// - Bits 12-13 pre-start and post-stop intervals
// - Bit14 alarm, bit15 fault
`timescale 1ns/1ps
module ssr_status #(
  parameter int ADDR_W = 8 // APB address width
) (
  input  wire logic              clk,          // System clock
  input  wire logic              rstn,         // Sync reset, active low
  input  wire logic [ADDR_W-1:0] paddr,        // APB address
  input  wire logic              psel,         // APB select
  input  wire logic              penable,      // APB enable
  input  wire logic              pwrite,       // APB direction
  input  wire logic [31:0]       pwdata,       // APB write data
  input  wire logic [3:0]        pstrb,        // APB byte strobes
  output logic [31:0]            prdata,       // APB read data
  output logic                   pready,       // APB ready
  output logic                   pslverr,      // APB error
  input  wire ssr_pkg::ssr_cond_t cond_in,     // Controller conditions
  output logic [3:0]             state_code,   // Live state code
  output logic [3:0]             origin_code,  // Live origin code
  output logic [15:0]            flag_word,    // Live flag word
  output logic                   report_ready  // Settling finished
);

  // Settling sequence state
  ssr_pkg::ssr_phase_t phase;      // Current phase
  ssr_pkg::ssr_phase_t next_phase; // Next phase
  logic [4:0]          hold_cnt;   // Settling cycles done
  logic [4:0]          next_hold_cnt;
  logic                init_hold;  // Report held at config

  // Report registers
  logic [3:0]  next_origin_code; // Next origin
  logic [15:0] next_flag_word;   // Next flag word
  logic        next_report_ready;

  // Software view and control
  logic        freeze;       // Software view frozen
  logic        next_freeze;
  logic [3:0]  snap_state;   // Frozen state code
  logic [3:0]  snap_origin;  // Frozen origin
  logic [15:0] snap_flags;   // Frozen flag word
  logic [3:0]  next_snap_state;
  logic [3:0]  next_snap_origin;
  logic [15:0] next_snap_flags;

  // Bus answer registers
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;

  // Bus decode
  logic        setup_phase; // First cycle of a transfer
  logic        wr_commit;   // Write takes effect
  logic [7:0]  word_addr;   // Byte address, low byte
  logic        addr_high;   // Address bits above the byte map set

  // Classify an offset as mapped or not
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == ssr_pkg::OFS_STATE)  || (a == ssr_pkg::OFS_ORIGIN) ||
                (a == ssr_pkg::OFS_FLAGS)  || (a == ssr_pkg::OFS_CTRL);
  endfunction

  // Pack an origin code from source and locality
  function automatic logic [3:0] origin_of(input logic [2:0] src,
                                          input logic       remote);
    origin_of = {src, remote};
  endfunction

  assign init_hold   = (phase == ssr_pkg::PH_INIT);
  assign setup_phase = psel && !penable;
  assign wr_commit   = psel && penable && pready && pwrite;
  assign word_addr   = 8'(paddr);
  // Shift rather than slice, so an 8-bit bus leaves no empty range
  assign addr_high   = |(paddr >> 8);

  // Settling sequence: hold config report for a fixed time after reset
  always_comb begin
    next_phase    = phase;
    next_hold_cnt = hold_cnt;
    case (phase)
      ssr_pkg::PH_INIT: begin
        if (hold_cnt == ssr_pkg::INIT_CYCLES - 5'h01) begin
          next_phase = ssr_pkg::PH_RUN;
        end else begin
          next_hold_cnt = hold_cnt + 5'h01;
        end
      end
      ssr_pkg::PH_RUN: begin
        next_phase = ssr_pkg::PH_RUN; // Stays until reset
      end
      default: begin
        next_phase = ssr_pkg::PH_INIT;
      end
    endcase
  end

  // Register the settling sequence
  always_ff @(posedge clk) begin
    if (!rstn) begin
      phase    <= ssr_pkg::PH_INIT;
      hold_cnt <= 5'h00;
    end else begin
      phase    <= next_phase;
      hold_cnt <= next_hold_cnt;
    end
  end

  // State code ranking lives in its own module
  ssr_state_encoder i_ssr_state_encoder (
    .clk           (clk),
    .rstn          (rstn),
    .flags         (cond_in.flags),
    .cfg           (cond_in.cfg),
    .start_delay   (cond_in.start_delay),
    .restart_delay (cond_in.restart_delay),
    .hold          (init_hold),
    .state_code    (state_code)
  );

  // Flag word and origin code from the live conditions
  always_comb begin
    next_report_ready = !init_hold;
    if (init_hold) begin
      next_flag_word = ssr_pkg::RST_FLAGS;
    end else begin
      // Struct order matches bit order 15 down to 0
      next_flag_word = 16'(cond_in.flags);
    end
    if (cond_in.cmd_src <= ssr_pkg::SRC_LAST) begin
      // Even code local, odd remote
      next_origin_code = origin_of(cond_in.cmd_src,
                                   cond_in.flags.remote_control);
    end else begin
      next_origin_code = origin_code; // Illegal source keeps last code
    end
  end

  // Register the live report
  always_ff @(posedge clk) begin
    if (!rstn) begin
      flag_word    <= ssr_pkg::RST_FLAGS;
      origin_code  <= ssr_pkg::RST_ORIGIN;
      report_ready <= 1'b0;
    end else begin
      flag_word    <= next_flag_word;
      origin_code  <= next_origin_code;
      report_ready <= next_report_ready;
    end
  end

  // Control register and frozen software view
  always_comb begin
    next_freeze      = freeze;
    next_snap_state  = snap_state;
    next_snap_origin = snap_origin;
    next_snap_flags  = snap_flags;
    if (wr_commit && (word_addr == ssr_pkg::OFS_CTRL) && pstrb[0]) begin
      next_freeze = pwdata[ssr_pkg::CTRL_FREEZE_BIT];
    end
    // Snapshot follows live values while not frozen, so the three
    // registers read as one coherent set once freeze is set
    if (!freeze) begin
      next_snap_state  = state_code;
      next_snap_origin = origin_code;
      next_snap_flags  = flag_word;
    end
  end

  // Register control and snapshot
  always_ff @(posedge clk) begin
    if (!rstn) begin
      freeze      <= 1'b0;
      snap_state  <= ssr_pkg::RST_STATE;
      snap_origin <= ssr_pkg::RST_ORIGIN;
      snap_flags  <= ssr_pkg::RST_FLAGS;
    end else begin
      freeze      <= next_freeze;
      snap_state  <= next_snap_state;
      snap_origin <= next_snap_origin;
      snap_flags  <= next_snap_flags;
    end
  end

  // APB answer: ready one cycle after setup, every access one wait-free
  always_comb begin
    next_pready  = setup_phase;
    next_prdata  = 32'h0000_0000;
    next_pslverr = 1'b0;
    if (setup_phase) begin
      if (!is_mapped(word_addr) || addr_high) begin
        next_pslverr = 1'b1; // Unmapped address
      end else if (pwrite && (word_addr != ssr_pkg::OFS_CTRL)) begin
        next_pslverr = 1'b1; // Status registers are read-only
      end else if (!pwrite) begin
        case (word_addr)
          ssr_pkg::OFS_STATE: begin
            next_prdata = {28'h0000000, snap_state};
          end
          ssr_pkg::OFS_ORIGIN: begin
            next_prdata = {28'h0000000, snap_origin};
          end
          ssr_pkg::OFS_FLAGS: begin
            next_prdata = {16'h0000, snap_flags};
          end
          ssr_pkg::OFS_CTRL: begin
            next_prdata = {31'h00000000, freeze};
          end
          default: begin
            next_prdata = 32'h0000_0000;
          end
        endcase
      end
    end
  end

  // Register the bus answer
  always_ff @(posedge clk) begin
    if (!rstn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // Reported state code stays legal and skips the reserved value
  a_state_legal : assert property (@(posedge clk) disable iff (!rstn)
    (state_code <= ssr_pkg::ST_CONFIG) &&
    (state_code != ssr_pkg::ST_RESERVED))
    else $error("state code out of range");

  // Fault present yields fault code one cycle later
  a_fault_code : assert property (@(posedge clk) disable iff (!rstn)
    (!init_hold && !(|cond_in.cfg) && cond_in.flags.fault)
    |=> state_code == ssr_pkg::ST_FAULT)
    else $error("fault did not give state 2");

  // Ramp state and ramp flag agree
  a_ramp_agree : assert property (@(posedge clk) disable iff (!rstn)
    (state_code == ssr_pkg::ST_RAMPUP) |-> flag_word[ssr_pkg::FLAG_RAMPUP_BIT])
    else $error("ramp state without ramp flag");

  // Any configuration cause reports code 14
  a_config_code : assert property (@(posedge clk) disable iff (!rstn)
    (|cond_in.cfg) |=> state_code == ssr_pkg::ST_CONFIG)
    else $error("config cause did not give state 14");

  // Origin code follows source and locality
  a_origin_code : assert property (@(posedge clk) disable iff (!rstn)
    (cond_in.cmd_src <= ssr_pkg::SRC_LAST)
    |=> origin_code == {$past(cond_in.cmd_src),
                        $past(cond_in.flags.remote_control)})
    else $error("origin code mismatch");

  // Odd origin and remote flag agree after settling
  a_origin_parity : assert property (@(posedge clk) disable iff (!rstn)
    (!init_hold && cond_in.cmd_src <= ssr_pkg::SRC_LAST) ##1 !init_hold
    |-> origin_code[0] == flag_word[ssr_pkg::FLAG_REMOTE_BIT])
    else $error("origin parity differs from remote flag");

  // Low flag bits track motor, enables, inching and tests
  a_low_flags : assert property (@(posedge clk) disable iff (!rstn)
    !init_hold |=> flag_word[3:0] == {$past(cond_in.flags.initial_test),
                                      $past(cond_in.flags.inching),
                                      $past(cond_in.flags.all_enables),
                                      $past(cond_in.flags.motor_enabled)})
    else $error("flag bits 0 to 3 wrong");

  // High flag bits track their conditions
  a_high_flags : assert property (@(posedge clk) disable iff (!rstn)
    !init_hold |=> flag_word[15:9] == 7'($past(16'(cond_in.flags)) >> 9))
    else $error("flag bits 9 to 15 wrong");

  // Fault code always carries the fault flag
  a_fault_flag : assert property (@(posedge clk) disable iff (!rstn)
    (state_code == ssr_pkg::ST_FAULT) |-> flag_word[ssr_pkg::FLAG_FAULT_BIT])
    else $error("fault state without fault flag");

  // Reset leaves config code and clear flags
  a_reset_view : assert property (@(posedge clk)
    !rstn |=> (state_code == ssr_pkg::ST_CONFIG) && (flag_word == 16'h0000))
    else $error("reset view wrong");

  // Settling lasts exactly its cycle count
  a_settle_len : assert property (@(posedge clk) disable iff (!rstn)
    $rose(report_ready) |-> $past(hold_cnt, 2) == ssr_pkg::INIT_CYCLES - 5'h01)
    else $error("settling length wrong");

  // Settling phase reports a clear flag word
  a_settle_flags : assert property (@(posedge clk) disable iff (!rstn)
    init_hold |=> flag_word == ssr_pkg::RST_FLAGS)
    else $error("flags not clear while settling");

  // Missing enable reports general disable
  a_disabled_code : assert property (@(posedge clk) disable iff (!rstn)
    (!init_hold && !(|cond_in.cfg) && !cond_in.flags.fault &&
     !cond_in.flags.initial_test && !cond_in.flags.all_enables)
    |=> state_code == ssr_pkg::ST_DISABLED)
    else $error("missing enable did not give state 13");

  // Illegal source leaves the origin code alone
  a_origin_hold : assert property (@(posedge clk) disable iff (!rstn)
    (cond_in.cmd_src > ssr_pkg::SRC_LAST) |=> $stable(origin_code))
    else $error("origin code moved on illegal source");

  // State register read returns the software view
  a_state_read : assert property (@(posedge clk) disable iff (!rstn)
    (setup_phase && !pwrite && !addr_high &&
     (word_addr == ssr_pkg::OFS_STATE))
    |=> prdata == {28'h0000000, $past(snap_state)})
    else $error("state register read wrong");

  // Main scenarios
  c_fault_seen : cover property (@(posedge clk) disable iff (!rstn)
    state_code == ssr_pkg::ST_FAULT);
  c_ramp_to_bypass : cover property (@(posedge clk) disable iff (!rstn)
    state_code == ssr_pkg::ST_RAMPUP ##[1:20]
    state_code == ssr_pkg::ST_BYPASS);
  c_remote_slot : cover property (@(posedge clk) disable iff (!rstn)
    origin_code == 4'hb);
  c_frozen_read : cover property (@(posedge clk) disable iff (!rstn)
    freeze && psel && penable && pready && !pwrite);
  c_settle_done : cover property (@(posedge clk) disable iff (!rstn)
    $rose(report_ready));

endmodule

// >>> test_ssr_status.sv
/*
  Self-checking bench for ssr_status: APB reads and writes with expected
  values worked out from the state, origin and flag word coding.
  Assumes the package register map and a 200 MHz clock.
*/
`timescale 1ns/1ps
module test_ssr_status;
  logic               clk;          // System clock
  logic               rstn;         // Sync reset, active low
  logic [7:0]         paddr;        // APB address
  logic               psel;         // APB select
  logic               penable;      // APB enable
  logic               pwrite;       // APB direction
  logic [31:0]        pwdata;       // APB write data
  logic [3:0]         pstrb;        // APB byte strobes
  logic [31:0]        prdata;       // APB read data
  logic               pready;       // APB ready
  logic               pslverr;      // APB error
  ssr_pkg::ssr_cond_t cond;         // Controller conditions
  logic [3:0]         state_code;   // Live state code
  logic [3:0]         origin_code;  // Live origin code
  logic [15:0]        flag_word;    // Live flag word
  logic               report_ready; // Settling finished
  logic [31:0]        rd;           // Last read data
  logic               er;           // Last error response
  int                 errors;       // Mismatch count
  int                 n_checks;     // Comparison count

  ssr_status i_ssr_status (
    .clk(clk), .rstn(rstn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cond_in(cond),
    .state_code(state_code), .origin_code(origin_code),
    .flag_word(flag_word), .report_ready(report_ready)
  );

  // 5 ns clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Verdict and end of run
  task automatic report_and_stop();
    $display("Checks %0d, errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Compare seen against expected
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    pstrb  <= s;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) errors++;
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Read a register, expect data and no error
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, 4'h0);
    chk(rd, exp);
    chk(32'(er), 32'h0);
  endtask

  // Apply conditions and let the registered outputs follow
  task automatic setc(input logic [15:0] f, input logic [4:0] c,
                      input logic sd, input logic rs, input logic [2:0] s);
    @(posedge clk);
    cond <= {f, c, sd, rs, s};
    repeat (2) @(posedge clk);
  endtask

  // Conditions to expected state code, port and registers
  task automatic st(input logic [15:0] f, input logic [4:0] c,
                    input logic sd, input logic rs, input logic [3:0] exp);
    setc(f, c, sd, rs, 3'h0);
    chk(32'(state_code), 32'(exp));
    rdchk(ssr_pkg::OFS_STATE, 32'(exp));
    rdchk(ssr_pkg::OFS_FLAGS, {16'h0, f});
  endtask

  // Main sequence
  initial begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'h0;
    errors = 0;
    n_checks = 0;
    cond = {16'h8002, 5'h00, 2'b00, 3'h0};
    repeat (12) @(posedge clk);
    chk(32'(state_code), 32'he);
    chk(32'(flag_word), 32'h0);
    rstn <= 1'b1;
    rdchk(ssr_pkg::OFS_STATE, 32'he);
    rdchk(ssr_pkg::OFS_FLAGS, 32'h0);
    rdchk(ssr_pkg::OFS_ORIGIN, 32'h0);
    for (int n = 0; n < 100 && report_ready !== 1'b1; n++) @(posedge clk);
    chk(32'(report_ready), 32'h1);
    // State table, ready first, then in priority order below config, config causes last
    st(16'h0002, 5'h00, 1'b0, 1'b0, 4'h0);
    st(16'h8002, 5'h00, 1'b0, 1'b0, 4'h2);
    st(16'h000a, 5'h00, 1'b0, 1'b0, 4'h1);
    st(16'h0000, 5'h00, 1'b0, 1'b0, 4'hd);
    st(16'h0202, 5'h00, 1'b0, 1'b0, 4'h8);
    st(16'h0402, 5'h00, 1'b0, 1'b0, 4'h9);
    st(16'h0006, 5'h00, 1'b0, 1'b0, 4'ha);
    st(16'h0082, 5'h00, 1'b0, 1'b0, 4'h7);
    st(16'h0012, 5'h00, 1'b0, 1'b0, 4'h3);
    st(16'h0042, 5'h00, 1'b0, 1'b0, 4'h5);
    st(16'h0022, 5'h00, 1'b0, 1'b0, 4'h4);
    st(16'h0002, 5'h00, 1'b1, 1'b0, 4'hb);
    st(16'h0002, 5'h00, 1'b0, 1'b1, 4'hc);
    for (int i = 0; i < 5; i++) begin
      st(16'h8002, 5'(1 << i), 1'b0, 1'b0, 4'he);
    end
    // Each flag bit alone
    for (int i = 0; i < 16; i++) begin
      setc(16'h0001 << i, 5'h00, 1'b0, 1'b0, 3'h0);
      chk(32'(flag_word), 32'(16'h0001 << i));
      rdchk(ssr_pkg::OFS_FLAGS, 32'(16'h0001 << i));
    end
    // Every origin code, local then remote
    for (int s = 0; s < 6; s++) begin
      for (int r = 0; r < 2; r++) begin
        setc(16'h0002 | 16'(r << 8), 5'h00, 1'b0, 1'b0, 3'(s));
        rdchk(ssr_pkg::OFS_ORIGIN, 32'(s * 2 + r));
        chk(32'(origin_code), 32'(s * 2 + r));
      end
    end
    setc(16'h0002, 5'h00, 1'b0, 1'b0, 3'h6);
    rdchk(ssr_pkg::OFS_ORIGIN, 32'hb);
    // Refused accesses
    apb(1'b0, 8'h10, 32'h0, 4'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, ssr_pkg::OFS_STATE, 32'h5, 4'hf);
    chk({31'h0, er}, 32'h1);
    rdchk(ssr_pkg::OFS_STATE, 32'h0);
    // Frozen view holds while live ports move
    setc(16'h8002, 5'h00, 1'b0, 1'b0, 3'h0);
    apb(1'b1, ssr_pkg::OFS_CTRL, 32'h1, 4'hf);
    setc(16'h0002, 5'h00, 1'b0, 1'b0, 3'h0);
    chk(32'(state_code), 32'h0);
    rdchk(ssr_pkg::OFS_STATE, 32'h2);
    rdchk(ssr_pkg::OFS_CTRL, 32'h1);
    apb(1'b1, ssr_pkg::OFS_CTRL, 32'h0, 4'hf);
    rdchk(ssr_pkg::OFS_STATE, 32'h0);
    apb(1'b1, ssr_pkg::OFS_CTRL, 32'h1, 4'h0);
    rdchk(ssr_pkg::OFS_CTRL, 32'h0);
    // Second reset in mid-run, with the view frozen beforehand
    apb(1'b1, ssr_pkg::OFS_CTRL, 32'h1, 4'hf);
    setc(16'h8002, 5'h00, 1'b0, 1'b0, 3'h0);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    chk(32'(state_code), 32'he);
    chk(32'(flag_word), 32'h0);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    chk(32'(state_code), 32'he);
    chk(32'(report_ready), 32'h0);
    rdchk(ssr_pkg::OFS_CTRL, 32'h0);
    rdchk(ssr_pkg::OFS_STATE, 32'he);
    for (int n = 0; n < 100 && report_ready !== 1'b1; n++) @(posedge clk);
    chk(32'(state_code), 32'h2);
    report_and_stop();
  end

  // Watchdog, far beyond the expected run length
  initial begin
    #200000;
    errors++;
    report_and_stop();
  end
endmodule
